// File: bench/csr_core_model.sv
`timescale 1ns/100ps
module csr_core_model
  import csr_pkg::*;
(
  input  csr_alu_req_t req,
  input  logic         cin,
  output logic [7:0]   r,
  output logic [2:0]   f,
  output logic [2:0]   m
);
  logic       sub;
  logic [7:0] bb;
  logic [8:0] s;
  logic [4:0] n;
  always_comb begin
    sub = (req.op == CSR_OP_SUB);
    bb = sub ? ~req.b : req.b;
    s = {1'b0, req.a} + {1'b0, bb} + 9'(sub);
    n = {1'b0, req.a[3:0]} + {1'b0, bb[3:0]} + 5'(sub);
    r = s[7:0];
    m = 3'h7;
    if (req.op == CSR_OP_LOGIC) begin
      r = req.a;
      m = 3'h4;
    end
    f = {r == 8'h00, n[4], s[8]};
    if (req.op == CSR_OP_ROT) begin
      r = req.rot_left ? {req.a[6:0], cin} : {cin, req.a[7:1]};
      f[0] = req.rot_left ? req.a[7] : req.a[0];
      m = 3'h1;
    end
    if (req.op == CSR_OP_NONE) m = 3'h0;
  end
endmodule : csr_core_model

// File: bench/csr_status_monitor.sv
`timescale 1ns/100ps
module csr_status_monitor
  import csr_pkg::*;
(
  input logic       clk,
  input logic       rst_n,
  input logic       alu_valid,
  input logic       wr_en,
  input logic [7:0] wr_data,
  input logic       wdt_clear,
  input logic       sleep_exec,
  input logic       wdt_timeout,
  input logic [6:0] dir_addr,
  input logic [7:0] status_q,
  input logic [8:0] dir_mem_addr_q
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  ro_flags_a: assert property (wr_en && !wdt_clear && !sleep_exec && !wdt_timeout
    |=> $stable(status_q[4:3])) else $error("cause flags written");
  wdt_clr_a: assert property (wdt_clear && !sleep_exec && !wdt_timeout
    |=> status_q[4:3] == 2'h3) else $error("clear wrong");
  sleep_a: assert property (sleep_exec && !wdt_timeout
    |=> status_q[4:3] == 2'h2) else $error("sleep wrong");
  timeout_a: assert property (wdt_timeout |=> !status_q[4]) else $error("timeout");
  page_wr_a: assert property (wr_en
    |=> status_q[7:5] == $past(wr_data[7:5])) else $error("page write");
  dir_addr_a: assert property (1'b1
    |=> dir_mem_addr_q == $past({status_q[6:5], dir_addr})) else $error("direct address");
  plain_wr_a: assert property (wr_en && !alu_valid
    |=> status_q[2:0] == $past(wr_data[2:0])) else $error("flag write");
  flag_hold_a: assert property (!wr_en && !alu_valid
    |=> $stable(status_q[2:0])) else $error("flags moved");
endmodule : csr_status_monitor

bind csr_status csr_status_monitor mon (.clk, .rst_n, .alu_valid, .wr_en, .wr_data,
  .wdt_clear, .sleep_exec, .wdt_timeout, .dir_addr, .status_q, .dir_mem_addr_q);

// File: bench/tb.sv
`timescale 1ns/100ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin fail_count++; \
  $display("Error t=%0t got=%h exp=%h", $time, a, b); end end
module tb;
  import csr_pkg::*;
  logic         clk = 0, rst_n = 0, alu_valid = 0, wr_en = 0;
  logic         wdt_clear = 0, sleep_exec = 0, wdt_timeout = 0;
  csr_alu_req_t req = '{CSR_OP_NONE, 8'h00, 8'h00, 1'b0};
  logic [7:0]   wr_data = 8'h00, ind_addr = 8'hA5, st, r, r_q, re, e;
  logic [6:0]   dir_addr = 7'h00;
  logic [8:0]   dm, im;
  logic [2:0]   f, m;
  int           fail_count = 0, samples_checked = 0;
  always #50 clk = ~clk;
  csr_status dut (.clk, .rst_n, .alu_req(req), .alu_valid, .wr_en, .wr_data, .wdt_clear,
    .sleep_exec, .wdt_timeout, .dir_addr, .ind_addr, .status_q(st), .alu_result_q(r_q),
    .dir_mem_addr_q(dm), .ind_mem_addr_q(im));
  csr_core_model mdl (.req, .cin(st[0]), .r, .f, .m);
  task automatic exe(csr_op_t op, logic [7:0] a, b, logic rl, w, logic [7:0] d);
    // one idle edge between calls so no strobe is lowered and raised in one step
    @(negedge clk);
    req = '{op, a, b, rl};
    // a plain move carries no flag results, so it goes in as a bare write
    {alu_valid, wr_en, wr_data} = {op != CSR_OP_NONE, w, d};
    // model output settles before the expectation is frozen
    #1 e = {w ? d[7:5] : st[7:5], st[4:3], (m & f) | (~m & (w ? d[2:0] : st[2:0]))};
    re = r;
    @(negedge clk) {alu_valid, wr_en} = 2'h0;
    `CHK(st, e)
    if (m != 3'h0) `CHK(r_q, re)
  endtask : exe
  task automatic ev(logic [2:0] v, logic [1:0] x);
    @(negedge clk);
    {wdt_timeout, wdt_clear, sleep_exec} = v;
    @(negedge clk) {wdt_timeout, wdt_clear, sleep_exec} = 3'h0;
    `CHK(st[4:3], x)
  endtask : ev
  task automatic t_arith;
    exe(CSR_OP_ADD, 8'h0F, 8'h01, 0, 1, 8'hE7);
    exe(CSR_OP_ADD, 8'hFF, 8'h01, 0, 0, 8'h00);
    exe(CSR_OP_SUB, 8'h05, 8'h05, 0, 0, 8'h00);
    exe(CSR_OP_SUB, 8'h03, 8'h05, 0, 1, 8'h1F);
    exe(CSR_OP_LOGIC, 8'h00, 8'h00, 0, 1, 8'h00);
    exe(CSR_OP_ROT, 8'h80, 8'h00, 1, 0, 8'h00);
    exe(CSR_OP_ROT, 8'h01, 8'h00, 0, 1, 8'hFE);
    exe(CSR_OP_NONE, 8'h00, 8'h00, 0, 1, 8'h5A);
    $display("arith done");
  endtask : t_arith
  task automatic t_cause;
    ev(3'h4, 2'h1);
    ev(3'h2, 2'h3);
    ev(3'h1, 2'h2);
    ev(3'h2, 2'h3);
    $display("cause done");
  endtask : t_cause
  task automatic t_addr;
    for (int i = 0; i < 4; i++) begin
      exe(CSR_OP_NONE, 8'h00, 8'h00, 0, 1, {i[0], i[1:0], 5'h00});
      dir_addr = 7'h7F ^ 7'(i);
      @(negedge clk);
      `CHK(dm, {i[1:0], dir_addr})
      `CHK(im, {i[0], ind_addr})
    end
    $display("addr done");
  endtask : t_addr
  task automatic final_report;
    $display("checks=%0d mismatches=%0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : final_report
  initial begin
    #200000 fail_count++;
    final_report;
  end
  initial begin
    repeat (10) @(negedge clk);
    `CHK(st, 8'h18)
    rst_n = 1;
    t_arith;
    t_cause;
    t_addr;
    final_report;
  end
endmodule : tb

// File: core/csr_alu.sv
`timescale 1ns/100ps
module csr_alu
  import csr_pkg::*;
(
  input  csr_alu_req_t req,
  input  logic         carry_in,
  output csr_alu_res_t res
);
  logic [8:0] sum;
  logic [4:0] nib;
  logic [7:0] b_eff;
  logic       cin;

  always_comb begin
    res   = '0;
    b_eff = (req.op == CSR_OP_SUB) ? ~req.b : req.b; // see [R11]
    cin   = (req.op == CSR_OP_SUB);
    sum   = {1'b0, req.a} + {1'b0, b_eff} + {8'h00, cin};
    nib   = {1'b0, req.a[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, cin};
    unique case (req.op)
      CSR_OP_ADD, CSR_OP_SUB: begin
        res.result = sum[7:0];
        res.nibble = nib[4]; // see [R9]
        res.carry  = sum[8]; // see [R10]
        res.upd_z  = 1'b1;
        res.upd_dc = 1'b1;
        res.upd_c  = 1'b1;
      end
      CSR_OP_LOGIC: begin
        res.result = req.a;
        res.upd_z  = 1'b1;
      end
      CSR_OP_ROT: begin
        // rotate only touches carry
        if (req.rot_left) begin
          res.result = {req.a[6:0], carry_in};
          res.carry  = req.a[7]; // see [R12]
        end else begin
          res.result = {carry_in, req.a[7:1]};
          res.carry  = req.a[0]; // see [R12]
        end
        res.upd_c = 1'b1;
      end
      CSR_OP_NONE: res.result = req.a;
    endcase
    res.zero = (res.result == 8'h00); // see [R8]
  end
endmodule : csr_alu

// File: core/csr_pkg.sv
package csr_pkg;
  localparam int unsigned CSR_WIDTH      = 8;
  localparam int unsigned BIT_IND_PAGE   = 7;
  localparam int unsigned BIT_PAGE_HI    = 6;
  localparam int unsigned BIT_PAGE_LO    = 5;
  localparam int unsigned BIT_WDT_EXP    = 4;
  localparam int unsigned BIT_PWR_DOWN   = 3;
  localparam int unsigned BIT_ZERO       = 2;
  localparam int unsigned BIT_NIBBLE     = 1;
  localparam int unsigned BIT_CARRY      = 0;
  localparam int unsigned DIR_ADDR_WIDTH = 7;
  localparam int unsigned MEM_ADDR_WIDTH = 9;
  localparam logic [2:0]  RST_PAGES      = 3'h0;
  localparam logic [1:0]  RST_RESET_FLAGS = 2'h3;
  localparam logic [2:0]  RST_ALU_FLAGS  = 3'h0;

  typedef enum logic [4:0] {
    CSR_OP_NONE  = 5'h01,
    CSR_OP_ADD   = 5'h02,
    CSR_OP_SUB   = 5'h04,
    CSR_OP_LOGIC = 5'h08,
    CSR_OP_ROT   = 5'h10
  } csr_op_t;

  typedef struct packed {
    csr_op_t    op;
    logic [7:0] a;
    logic [7:0] b;
    logic       rot_left;
  } csr_alu_req_t;

  typedef struct packed {
    logic [7:0] result;
    logic       zero;
    logic       nibble;
    logic       carry;
    logic       upd_z;
    logic       upd_dc;
    logic       upd_c;
  } csr_alu_res_t;
endpackage : csr_pkg

// File: core/csr_status.sv
`timescale 1ns/100ps
// Functional notes
// [R1] status register is writable as any instruction's destination, with flag exceptions
// [R2] flag-affecting write to status: zero/nibble/carry take ALU results, not data; here only flags the op updates ignore data (logic: zero, rotate: carry)
// [R3] watchdog-expired and power-down flags ignore all writes
// [R4] indirect page bit selects banks 2-3 when set, 0-1 when clear
// [R5] two direct page bits choose one of four 128-byte banks
// [R6] watchdog flag set by power-up, clear-watchdog, sleep; cleared by time-out
// [R7] power-down flag set by power-up or clear-watchdog; cleared by sleep
// [R8] zero flag follows whether the operation result equals zero
// [R9] nibble flag is carry out of bit 3 for add and subtract
// [R10] carry flag is carry out of bit 7 for add and subtract
// [R11] subtract adds two's complement; carries are inverted borrows
// [R12] rotates load carry with the bit shifted out
// [R13] software should modify status only with non-flag-affecting instructions
// [R14] reset: page bits 0, reset-cause flags 1, ALU flags undefined
// [R15] direct address is page bits above seven-bit instruction field
module csr_status
  import csr_pkg::*;
(
  input  logic                      clk,
  input  logic                      rst_n,
  input  csr_alu_req_t              alu_req,
  input  logic                      alu_valid,
  input  logic                      wr_en,
  input  logic [CSR_WIDTH-1:0]      wr_data,
  input  logic                      wdt_clear,
  input  logic                      sleep_exec,
  input  logic                      wdt_timeout,
  input  logic [DIR_ADDR_WIDTH-1:0] dir_addr,
  input  logic [7:0]                ind_addr,
  output logic [CSR_WIDTH-1:0]      status_q,
  output logic [7:0]                alu_result_q,
  output logic [MEM_ADDR_WIDTH-1:0] dir_mem_addr_q,
  output logic [MEM_ADDR_WIDTH-1:0] ind_mem_addr_q
);
  csr_alu_res_t res;
  logic [2:0]   page_q;
  logic [1:0]   rst_flags_q;
  logic [2:0]   alu_flags_q;

  csr_alu u_alu (
    .req      (alu_req),
    .carry_in (alu_flags_q[BIT_CARRY]),
    .res      (res)
  );

  // page bits: plain file-register write
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      page_q <= RST_PAGES; // see [R14]
    end else if (wr_en) begin
      page_q <= wr_data[BIT_IND_PAGE:BIT_PAGE_LO]; // see [R1]
    end
  end

  // reset-cause flags; writes never reach them, see [R3]
  // time-out wins over a same-cycle clear so the event is not lost
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_flags_q <= RST_RESET_FLAGS; // see [R14]
    end else begin
      if (wdt_timeout) begin
        rst_flags_q[1] <= 1'b0; // see [R6]
      end else if (wdt_clear || sleep_exec) begin
        rst_flags_q[1] <= 1'b1; // see [R6]
      end
      if (sleep_exec) begin
        rst_flags_q[0] <= 1'b0; // see [R7]
      end else if (wdt_clear) begin
        rst_flags_q[0] <= 1'b1; // see [R7]
      end
    end
  end

  // alu flags: instruction results override written data, see [R2]
  // reset value is a don't-care to software; zero chosen for determinism
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      alu_flags_q <= RST_ALU_FLAGS; // see [R14]
    end else begin
      if (alu_valid && res.upd_z) begin
        alu_flags_q[BIT_ZERO] <= res.zero; // see [R2]
      end else if (wr_en) begin
        alu_flags_q[BIT_ZERO] <= wr_data[BIT_ZERO]; // see [R1]
      end
      if (alu_valid && res.upd_dc) begin
        alu_flags_q[BIT_NIBBLE] <= res.nibble; // see [R2]
      end else if (wr_en) begin
        alu_flags_q[BIT_NIBBLE] <= wr_data[BIT_NIBBLE];
      end
      if (alu_valid && res.upd_c) begin
        alu_flags_q[BIT_CARRY] <= res.carry; // see [R2]
      end else if (wr_en) begin
        alu_flags_q[BIT_CARRY] <= wr_data[BIT_CARRY];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      alu_result_q <= 8'h00;
    end else if (alu_valid) begin
      alu_result_q <= res.result;
    end
  end

  // addresses use the page bits already in effect this cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dir_mem_addr_q <= '0;
      ind_mem_addr_q <= '0;
    end else begin
      dir_mem_addr_q <= {page_q[1:0], dir_addr}; // see [R5] [R15]
      ind_mem_addr_q <= {page_q[2], ind_addr};   // see [R4]
    end
  end

  always_comb begin
    status_q = {page_q, rst_flags_q, alu_flags_q};
  end
endmodule : csr_status
